// ===== core/arl_map.svh
/*
 * Register offsets, field positions, reset values and widths of the
 * converter result latch port.
 * Assumes it is included by its bare name from core/ and sim/ files.
 */
`ifndef ARL_MAP_SVH
`define ARL_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define ARL_ADDR_W          4
`define ARL_DATA_W          16
`define ARL_ADDR_CTRL       4'h0
`define ARL_ADDR_STATUS     4'h1
`define ARL_ADDR_MASK       4'h2
`define ARL_ADDR_RESULT     4'h3
`define ARL_ADDR_STATE      4'h4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ARL_CTRL_LATCH_FIT  0
`define ARL_EV_EOC          0
`define ARL_EV_PAIR         1
`define ARL_EV_OVERRUN      2
`define ARL_EV_W            3
`define ARL_ST_FMT16        0
`define ARL_ST_WAIT_LOW     1
`define ARL_ST_BUSY         2

// ----------------------------------------------------------------------
// reset values and data layout
// ----------------------------------------------------------------------
`define ARL_CTRL_RST        1'h1
`define ARL_MASK_RST        3'h0
`define ARL_FMT16_RST       1'h1
`define ARL_RES_W           12
`define ARL_NIB_W           4
`define ARL_SYNC_W          18

`endif

// ===== core/arl_pkg.sv
/*
 * Types shared by the result latch port modules.
 * Assumes arl_map.svh is compiled alongside; holds no constants.
 */
`default_nettype none

package arl_pkg;

   // ----------------------------------------------------------------------
   // two-byte read sequence
   // ----------------------------------------------------------------------
   typedef enum logic [0:0] {
      ARL_WAIT_HIGH,
      ARL_WAIT_LOW
   } arl_seq_t;

   // rising edge of an active-low level, used for busy and read strobes
   function automatic logic arl_rise(input logic prev, input logic cur);
      arl_rise = cur & ~prev;
   endfunction

endpackage

`default_nettype wire

// ===== core/arl_latch_if.sv
/*
 * Carrier between the port controller and the result latch store.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "arl_map.svh"

interface arl_latch_if;
   logic                     load;     // full word load pulse
   logic [`ARL_RES_W-1:0]    word_in;
   logic                     nib_cap;  // low nibble capture pulse
   logic [`ARL_NIB_W-1:0]    nib_in;
   logic [`ARL_RES_W-1:0]    word_q;   // held result

   modport ctl   (output load, output word_in, output nib_cap,
                  output nib_in, input word_q);
   modport store (input load, input word_in, input nib_cap,
                  input nib_in, output word_q);
endinterface

`default_nettype wire

// ===== core/arl_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of pin levels.
 * Assumes every bit is a level that may change at any time.
 */
`timescale 1ns/10ps
`default_nettype none

module arl_sync #(
   parameter int W = 1
) (
   input  wire logic          core_clk,
   input  wire logic [W-1:0]  pin_in,
   output logic      [W-1:0]  lvl_out
);

   // ----------------------------------------------------------------------
   // synchroniser stages
   // ----------------------------------------------------------------------
   logic [W-1:0] meta_q;

   // no reset: the first stage feeds only the second
   always_ff @(posedge core_clk) begin
      meta_q  <= pin_in;
      lvl_out <= meta_q;
   end

endmodule

`default_nettype wire

// ===== core/arl_latch.sv
/*
 * Result latch store: upper byte and low nibble of the converter word.
 * Assumes load and capture are one-cycle pulses on the core clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "arl_map.svh"

module arl_latch (
   input  wire logic          core_clk,
   input  wire logic          sys_rst,
   arl_latch_if.store         lif
);

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   logic [`ARL_RES_W-1:0] word_d;
   logic [`ARL_RES_W-1:0] word_q;

   // full load beats nibble capture: the newer conversion wins
   always_comb begin
      word_d = word_q;
      if (lif.load) begin
         word_d = lif.word_in;
      end else if (lif.nib_cap) begin
         word_d[`ARL_NIB_W-1:0] = lif.nib_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         word_q <= 12'h000;
      end else begin
         word_q <= word_d;
      end
   end

   assign lif.word_q = word_q;

endmodule

`default_nettype wire

// ===== core/arl_top.sv
/*
 * Converter result latch and byte port: presents a 12-bit conversion
 * result to a 16-bit host, a 12-bit header and an 8-bit host.
 * Assumes all converter and host pins are asynchronous to core_clk and
 * the format link is static after reset.
 */
// Added by the designer: the strobed register port and the register offsets.
// Operation
// R1: 8-bit host reads high byte (bits 11..4) first, low nibble second.
// R2: end of first combined select/read strobe captures low nibble.
// R3: second byte read drives low nibble from the latch.
// R4: in byte format a latch holds four result bits for the second read.
// R5: busy rising edge loads the full result into the latches.
// R6: latched data reach the bus only while an output enable is asserted.
// R7: upper enable gates eight high bits, lower enable four low bits.
// R8: format link picks one 16-bit read or two separate byte enables.
// R9: 16-bit connector left justified, result bit 11 on host bit 15.
// R10: host data bits 3 down to 0 always read zero.
// R11: header connector carries only the twelve result bits.
// R12: with latches fitted converter select and read held low.
// R13: converter busy drives host interrupt line zero.
// R14: host selects the board with its board select strobe.
// R15: busy is the end-of-conversion interrupt before the result is read.

`timescale 1ns/10ps
`default_nettype none
`include "arl_map.svh"

module arl_top (
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire logic [`ARL_ADDR_W-1:0]  reg_addr,
   input  wire logic [`ARL_DATA_W-1:0]  reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [`ARL_DATA_W-1:0]  reg_rdata,
   input  wire logic [`ARL_RES_W-1:0]   conv_data,
   input  wire logic                    conv_busy_n,
   output logic                         conv_cs_n,
   output logic                         conv_rd_n,
   input  wire logic                    board_select_strobe_n,
   input  wire logic                    host_rd_n,
   input  wire logic                    upper_byte_output_enable_n,
   input  wire logic                    low_nibble_output_enable_n,
   input  wire logic                    word_format_select_link,
   output logic                         host_interrupt_line_zero_n,
   output logic      [15:0]             host_data_o,
   output logic      [15:0]             host_data_oe,
   output logic      [`ARL_RES_W-1:0]   hdr_data_o,
   output logic      [`ARL_RES_W-1:0]   hdr_data_oe,
   output logic      [7:0]              byte_data_o,
   output logic                         byte_data_oe,
   output logic                         irq
);

   // ----------------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------------
   logic [`ARL_SYNC_W-1:0] pins_s;
   logic [`ARL_RES_W-1:0]  conv_s;
   logic                   busy_n_s;
   logic                   sel_n_s;
   logic                   rd_n_s;
   logic                   oe_up_n_s;
   logic                   oe_lo_n_s;
   logic                   link_s;

   arl_sync #(.W(`ARL_SYNC_W)) u_sync (
      .core_clk (core_clk),
      .pin_in   ({conv_data, conv_busy_n, board_select_strobe_n,
                  host_rd_n, upper_byte_output_enable_n,
                  low_nibble_output_enable_n, word_format_select_link}),
      .lvl_out  (pins_s)
   );

   // unpack the synchronised bundle
   assign conv_s    = pins_s[17:6];
   assign busy_n_s  = pins_s[5];
   assign sel_n_s   = pins_s[4];
   assign rd_n_s    = pins_s[3];
   assign oe_up_n_s = pins_s[2];
   assign oe_lo_n_s = pins_s[1];
   assign link_s    = pins_s[0];

   // ----------------------------------------------------------------------
   // result latch store
   // ----------------------------------------------------------------------
   arl_latch_if lif ();

   arl_latch u_latch (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .lif      (lif)
   );

   // ----------------------------------------------------------------------
   // registers and next values
   // ----------------------------------------------------------------------
   logic                   fit_q, fit_d;         // latches fitted
   logic                   fmt16_q, fmt16_d;     // 16-bit format
   logic                   strap_q, strap_d;     // format caught
   logic                   busy_prev_q, busy_prev_d;
   logic                   strb_prev_q, strb_prev_d;
   arl_pkg::arl_seq_t      seq_q, seq_d;
   logic [`ARL_EV_W-1:0]   status_q, status_d;
   logic [`ARL_EV_W-1:0]   mask_q, mask_d;
   logic [`ARL_EV_W-1:0]   ev_set;
   logic [`ARL_DATA_W-1:0] rdata_q, rdata_d;
   logic                   eoc_rise;
   logic                   strb_n;
   logic                   strb_end;
   logic                   up_en;
   logic                   lo_en;
   logic [`ARL_RES_W-1:0]  result;

   // combined select and read strobe, low while the board is read
   assign strb_n   = sel_n_s | rd_n_s; // R14
   assign eoc_rise = arl_pkg::arl_rise(busy_prev_q, busy_n_s);
   assign strb_end = arl_pkg::arl_rise(strb_prev_q, strb_n);

   // without latches the converter drives the bus straight through
   assign result = fit_q ? lif.word_q : conv_s;

   // ----------------------------------------------------------------------
   // latch control
   // ----------------------------------------------------------------------
   // busy edge loads the whole word; byte mode grabs the nibble
   always_comb begin
      lif.load    = eoc_rise & fit_q; // R5
      lif.word_in = conv_s;
      lif.nib_cap = strb_end & ~fmt16_q & (seq_q == arl_pkg::ARL_WAIT_HIGH); // R2 R4
      lif.nib_in  = conv_s[`ARL_NIB_W-1:0];
   end

   // ----------------------------------------------------------------------
   // control state: format strap, edges, byte sequence
   // ----------------------------------------------------------------------
   always_comb begin
      strap_d     = 1'b1;
      fmt16_d     = strap_q ? fmt16_q : link_s; // R8
      busy_prev_d = busy_n_s;
      strb_prev_d = strb_n;
      seq_d       = seq_q;
      ev_set      = 3'h0;
      ev_set[`ARL_EV_EOC] = eoc_rise; // R15
      case (seq_q)
         arl_pkg::ARL_WAIT_HIGH: begin
            // the high byte must come first, nibble latched at its end
            if (strb_end && !fmt16_q) begin
               seq_d = arl_pkg::ARL_WAIT_LOW; // R1
            end
         end
         arl_pkg::ARL_WAIT_LOW: begin
            if (eoc_rise) begin
               // a new word before the low byte splits the pair
               ev_set[`ARL_EV_OVERRUN] = 1'b1;
               seq_d = arl_pkg::ARL_WAIT_HIGH;
            end else if (strb_end) begin
               ev_set[`ARL_EV_PAIR] = 1'b1;
               seq_d = arl_pkg::ARL_WAIT_HIGH;
            end
         end
         default: begin
            seq_d = arl_pkg::ARL_WAIT_HIGH;
         end
      endcase
      if (fmt16_q) begin
         seq_d = arl_pkg::ARL_WAIT_HIGH;
      end
   end

   // format is caught once, the first cycle after reset release
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         strap_q     <= 1'b0;
         fmt16_q     <= `ARL_FMT16_RST;
         busy_prev_q <= 1'b1;
         strb_prev_q <= 1'b1;
         seq_q       <= arl_pkg::ARL_WAIT_HIGH;
      end else begin
         strap_q     <= strap_d;
         fmt16_q     <= fmt16_d;
         busy_prev_q <= busy_prev_d;
         strb_prev_q <= strb_prev_d;
         seq_q       <= seq_d;
      end
   end

   // ----------------------------------------------------------------------
   // register port and interrupt status
   // ----------------------------------------------------------------------
   // a status read clears; an event in the same cycle still sets
   always_comb begin
      fit_d    = fit_q;
      mask_d   = mask_q;
      status_d = status_q;
      rdata_d  = 16'h0000;
      if (reg_wr) begin
         if (reg_addr == `ARL_ADDR_CTRL) begin
            fit_d = reg_wdata[`ARL_CTRL_LATCH_FIT];
         end else if (reg_addr == `ARL_ADDR_MASK) begin
            mask_d = reg_wdata[`ARL_EV_W-1:0];
         end
      end
      if (reg_rd) begin
         if (reg_addr == `ARL_ADDR_CTRL) begin
            rdata_d[`ARL_CTRL_LATCH_FIT] = fit_q;
         end else if (reg_addr == `ARL_ADDR_STATUS) begin
            rdata_d[`ARL_EV_W-1:0] = status_q;
            status_d = 3'h0;
         end else if (reg_addr == `ARL_ADDR_MASK) begin
            rdata_d[`ARL_EV_W-1:0] = mask_q;
         end else if (reg_addr == `ARL_ADDR_RESULT) begin
            rdata_d[`ARL_RES_W-1:0] = result;
         end else if (reg_addr == `ARL_ADDR_STATE) begin
            rdata_d[`ARL_ST_FMT16]    = fmt16_q;
            rdata_d[`ARL_ST_WAIT_LOW] = (seq_q == arl_pkg::ARL_WAIT_LOW);
            rdata_d[`ARL_ST_BUSY]     = ~busy_n_s;
         end else begin
            rdata_d = 16'h0000; // unmapped reads zero
         end
      end
      status_d = status_d | ev_set;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fit_q    <= `ARL_CTRL_RST;
         mask_q   <= `ARL_MASK_RST;
         status_q <= 3'h0;
         rdata_q  <= 16'h0000;
      end else begin
         fit_q    <= fit_d;
         mask_q   <= mask_d;
         status_q <= status_d;
         rdata_q  <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq       = |(status_q & mask_q);

   // ----------------------------------------------------------------------
   // host and converter pin drive
   // ----------------------------------------------------------------------
   logic        cs_n_d, rd_n_d, int_n_d, boe_d;
   logic        cs_n_q, rd_n_q, int_n_q, boe_q;
   logic [15:0] hd_d, hd_q, hoe_d, hoe_q;
   logic [7:0]  bd_d, bd_q;

   // in 16-bit format either enable drives the whole word together
   always_comb begin
      up_en   = fmt16_q ? ~(oe_up_n_s & oe_lo_n_s) : ~oe_up_n_s; // R8
      lo_en   = fmt16_q ? ~(oe_up_n_s & oe_lo_n_s) : ~oe_lo_n_s; // R8
      cs_n_d  = fit_q ? 1'b0 : sel_n_s; // R12
      rd_n_d  = fit_q ? 1'b0 : rd_n_s; // R12
      int_n_d = busy_n_s; // R13
      hd_d    = {result, 4'h0}; // R9 R10
      hoe_d   = {{8{up_en}}, {4{lo_en}}, {4{lo_en}}}; // R6 R7
      boe_d   = ~fmt16_q & ~strb_n;
      // high byte from result (latch word when fitted, else converter pins), second read from the latch
      if (seq_q == arl_pkg::ARL_WAIT_LOW) begin
         bd_d = {4'h0, lif.word_q[`ARL_NIB_W-1:0]}; // R3
      end else begin
         bd_d = result[11:4]; // R1
      end
   end

   // pins come from flops so the bus never sees a decode glitch
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cs_n_q  <= 1'b1;
         rd_n_q  <= 1'b1;
         int_n_q <= 1'b1;
         hd_q    <= 16'h0000;
         hoe_q   <= 16'h0000;
         bd_q    <= 8'h00;
         boe_q   <= 1'b0;
      end else begin
         cs_n_q  <= cs_n_d;
         rd_n_q  <= rd_n_d;
         int_n_q <= int_n_d;
         hd_q    <= hd_d;
         hoe_q   <= hoe_d;
         bd_q    <= bd_d;
         boe_q   <= boe_d;
      end
   end

   assign conv_cs_n                  = cs_n_q;
   assign conv_rd_n                  = rd_n_q;
   assign host_interrupt_line_zero_n = int_n_q;
   assign host_data_o                = hd_q;
   assign host_data_oe               = hoe_q;
   assign hdr_data_o                 = hd_q[15:4]; // R11
   assign hdr_data_oe                = hoe_q[15:4]; // R11
   assign byte_data_o                = bd_q;
   assign byte_data_oe               = boe_q;

endmodule

`default_nettype wire

// ===== sim/arl_top_monitor.sv
/*
 * Checker for the result latch port pins and register read port.
 * Assumes it is bound to arl_top and the format strap is static.
 */
`timescale 1ns/10ps
`default_nettype none
`include "arl_map.svh"

module arl_top_monitor (
   input wire logic                    core_clk,
   input wire logic                    sys_rst,
   input wire logic                    reg_rd,
   input wire logic [`ARL_DATA_W-1:0]  reg_rdata,
   input wire logic                    conv_busy_n,
   input wire logic                    conv_cs_n,
   input wire logic                    board_select_strobe_n,
   input wire logic                    host_rd_n,
   input wire logic                    upper_byte_output_enable_n,
   input wire logic                    low_nibble_output_enable_n,
   input wire logic                    word_format_select_link,
   input wire logic                    host_interrupt_line_zero_n,
   input wire logic [15:0]             host_data_o,
   input wire logic [15:0]             host_data_oe,
   input wire logic [`ARL_RES_W-1:0]   hdr_data_o,
   input wire logic [`ARL_RES_W-1:0]   hdr_data_oe,
   input wire logic                    byte_data_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------------------------------------
   // sequences: pin levels held long enough to pass the sync pipe
   // ----------------------------------------------------------------------
   sequence s_ena_off;
      (upper_byte_output_enable_n && low_nibble_output_enable_n) [*4];
   endsequence
   sequence s_upper_only;
      (!upper_byte_output_enable_n && low_nibble_output_enable_n &&
       !word_format_select_link) [*4];
   endsequence
   sequence s_fmt16_on;
      (word_format_select_link && !upper_byte_output_enable_n) [*4];
   endsequence

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read answer");
   a_bus_released: assert property (s_ena_off |-> host_data_oe == 16'h0000)
      else $error("host bus driven with enables off");
   a_upper_lanes: assert property (s_upper_only |-> host_data_oe == 16'hFF00)
      else $error("upper enable drives wrong lanes");
   a_fmt16_whole: assert property (s_fmt16_on |-> host_data_oe == 16'hFFFF)
      else $error("word format does not drive all lanes");
   a_byte_fmt_off: assert property (word_format_select_link |-> !byte_data_oe)
      else $error("byte port driven in word format");
   a_low_bits_zero: assert property (host_data_o[3:0] == 4'h0)
      else $error("host data low bits not zero");
   a_hdr_copy: assert property (
      hdr_data_o == host_data_o[15:4] && hdr_data_oe == host_data_oe[15:4])
      else $error("header lanes differ from word lanes");
   a_int_idle: assert property (
      conv_busy_n [*4] |-> host_interrupt_line_zero_n)
      else $error("interrupt line low while idle");
   a_int_busy: assert property (
      (!conv_busy_n) [*4] |-> !host_interrupt_line_zero_n)
      else $error("interrupt line high while busy");
   a_byte_strobe: assert property (
      $rose(byte_data_oe) |->
      !$past(board_select_strobe_n, 3) && !$past(host_rd_n, 3))
      else $error("byte port driven without strobe");
   a_cs_follows: assert property (
      $rose(conv_cs_n) |-> $past(board_select_strobe_n, 3))
      else $error("converter select released without cause");
endmodule

`default_nettype wire

// ===== sim/arl_conv_model.sv
/*
 * Behavioural converter at the far side of the result pins.
 * Assumes start is a one-cycle pulse from the bench on core_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module arl_conv_model (
   input  wire logic         core_clk,
   input  wire logic         cs_n,
   input  wire logic         rd_n,
   input  wire logic         start,
   input  wire logic [11:0]  value,
   output logic      [11:0]  conv_data,
   output logic              conv_busy_n
);
   logic [11:0] res_q;
   logic [3:0]  cnt_q;
   logic        rel_q;

   initial begin
      res_q       = 12'h000;
      cnt_q       = 4'h0;
      rel_q       = 1'b1;
      conv_data   = 12'h000;
      conv_busy_n = 1'b1;
   end

   // conversion timing: start comes from outside, busy ends it
   always @(posedge core_clk) begin
      if (start) begin
         conv_busy_n <= 1'b0;
         cnt_q       <= 4'hA;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h2) res_q <= value;       // data settle first
         if (cnt_q == 4'h1) conv_busy_n <= 1'b1;
      end
      rel_q <= cs_n | rd_n;
      // released outputs toggle so stale values cannot pass
      if (rel_q && (cs_n | rd_n)) conv_data <= ~conv_data;
      else conv_data <= res_q;
   end
endmodule

`default_nettype wire

// ===== sim/tb_arl_top.sv
/*
 * Self-checking bench for arl_top: register reads, word and byte reads.
 * Assumes arl_conv_model and arl_top_monitor are compiled beforehand.
 */
`timescale 1ns/10ps
`default_nettype none
`include "arl_map.svh"

module tb_arl_top;
   logic core_clk = 1'b0, sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [11:0] conv_data, conv_val = 12'h000, hdr_data_o, hdr_data_oe;
   logic conv_busy_n, conv_cs_n, conv_rd_n, start = 1'b0;
   logic sel_n = 1'b1, hrd_n = 1'b1, up_n = 1'b1, lo_n = 1'b1;
   logic link = 1'b1, int_n, irq, byte_data_oe;
   logic [15:0] host_data_o, host_data_oe;
   logic [7:0] byte_data_o;
   int miscompares = 0, n_compared = 0;

   always #50 core_clk = ~core_clk;

   arl_conv_model u_arl_conv_model (.core_clk(core_clk), .cs_n(conv_cs_n),
      .rd_n(conv_rd_n), .start(start), .value(conv_val),
      .conv_data(conv_data), .conv_busy_n(conv_busy_n));

   arl_top u_arl_top (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_data(conv_data),
      .conv_busy_n(conv_busy_n), .conv_cs_n(conv_cs_n),
      .conv_rd_n(conv_rd_n), .board_select_strobe_n(sel_n),
      .host_rd_n(hrd_n), .upper_byte_output_enable_n(up_n),
      .low_nibble_output_enable_n(lo_n), .word_format_select_link(link),
      .host_interrupt_line_zero_n(int_n), .host_data_o(host_data_o),
      .host_data_oe(host_data_oe), .hdr_data_o(hdr_data_o),
      .hdr_data_oe(hdr_data_oe), .byte_data_o(byte_data_o),
      .byte_data_oe(byte_data_oe), .irq(irq));

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic do_reset(input logic lk);
      @(posedge core_clk) sys_rst <= 1'b1;
      link <= lk;
      cyc(4);
      @(posedge core_clk) sys_rst <= 1'b0;
      cyc(1);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
      @(posedge core_clk) reg_wr <= 1'b0;
   endtask

   // read answer stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge core_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge core_clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask

   // pin change, then seven cycles: two sync flops and the output flop out to the converter and back
   task automatic pins(input logic s, input logic r, input logic u,
                       input logic l);
      @(posedge core_clk) begin sel_n <= s; hrd_n <= r; up_n <= u; lo_n <= l; end
      cyc(7);
   endtask

   task automatic convert(input logic [11:0] v);
      @(posedge core_clk) begin start <= 1'b1; conv_val <= v; end
      @(posedge core_clk) start <= 1'b0;
      cyc(6);
      chk(16'(int_n), 16'h0000);
      cyc(10);
   endtask

   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   initial begin
      do_reset(1'b1);
      chk(16'(int_n), 16'h0001);
      chk(host_data_oe, 16'h0000);
      rd(4'h0, 16'h0001);
      rd(4'h2, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h4, 16'h0001);
      rd(4'hF, 16'h0000);
      wr(4'h2, 16'h0007);
      convert(12'hA5C);
      chk(16'(irq), 16'h0001);
      rd(4'h1, 16'h0001);
      chk(16'(irq), 16'h0000);
      rd(4'h3, 16'h0A5C);
      chk(16'(conv_cs_n | conv_rd_n), 16'h0000);
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      chk(host_data_o, 16'hA5C0);
      chk(host_data_oe, 16'hFFFF);
      chk(16'(hdr_data_o), 16'h0A5C);
      pins(1'b1, 1'b1, 1'b1, 1'b0);
      chk(host_data_oe, 16'hFFFF);
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      chk(16'(byte_data_oe), 16'h0000);
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      chk(host_data_oe, 16'h0000);

      // two-byte format: separate lanes, then split byte reads
      do_reset(1'b0);
      rd(4'h4, 16'h0000);
      convert(12'h3C7);
      rd(4'h1, 16'h0001);
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      chk(host_data_oe, 16'hFF00);
      chk(16'(host_data_o[15:8]), 16'h003C);
      pins(1'b1, 1'b1, 1'b1, 1'b0);
      chk(host_data_oe, 16'h00FF);
      chk(16'(host_data_o[7:4]), 16'h0007);
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      wr(4'h0, 16'h0000);
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      chk(16'(conv_cs_n), 16'h0000);
      chk({byte_data_oe, 7'h00, byte_data_o}, 16'h803C);
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      chk(16'(byte_data_oe | !conv_cs_n), 16'h0000);
      rd(4'h4, 16'h0002);
      convert(12'h5E1);
      rd(4'h1, 16'h0005);
      rd(4'h4, 16'h0000);
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      chk({byte_data_oe, 7'h00, byte_data_o}, 16'h805E);
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      chk({byte_data_oe, 7'h00, byte_data_o}, 16'h8001);
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      rd(4'h1, 16'h0002);
      give_verdict();
   end

   // watchdog far beyond the few hundred cycles the tests need
   initial begin
      #2000000;
      miscompares++;
      give_verdict();
   end
endmodule

bind arl_top arl_top_monitor u_arl_top_monitor (.core_clk, .sys_rst,
   .reg_rd, .reg_rdata, .conv_busy_n, .conv_cs_n, .board_select_strobe_n,
   .host_rd_n, .upper_byte_output_enable_n, .low_nibble_output_enable_n,
   .word_format_select_link, .host_interrupt_line_zero_n, .host_data_o,
   .host_data_oe, .hdr_data_o, .hdr_data_oe, .byte_data_oe);

`default_nettype wire
